//--- dv/mms_host_model.sv
// mms_host_model: two-wire master in the host controller's place.
// assumes SDA open drain with pull-up; the device pulls via sda_oe.
`default_nettype none
module mms_host_model (
  input  wire logic clk,     // bench clock
  input  wire logic sda_oe,  // device pulls SDA
  output logic      scl,     // idle high between frames
  output logic      sda_w    // resolved SDA level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_h;
  assign sda_w = sda_h & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // 160 ns low, 160 ns high: the 320 ns link period
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #80 sda_h = b;
    #80 scl = 1'b1;
    #80 r = sda_w;
    #80;
  endtask
  task automatic frame(input logic [7:0] x, output logic [7:0] q,
                       output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(x[i], q[i]);
    bit_io(1'b1, nak);
  endtask
  // start when s=1, stop when s=0; long low phase lets an ack drop first
  task automatic cond(input logic s);
    scl = 1'b0;
    #200 sda_h = s;
    #40 scl = 1'b1;
    #160 sda_h = ~s;
    #160;
  endtask
  task automatic wr(input logic [7:0] o, x, output logic ack);
    logic [7:0] q;
    logic [2:0] n;
    @(posedge clk);
    #1 cond(1'b1);
    frame(8'hA0, q, n[0]);
    frame(o, q, n[1]);
    frame(x, q, n[2]);
    cond(1'b0);
    ack = (n === 3'h0);
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] d,
                    output logic ack);
    logic [7:0] q;
    logic [3:0] n;
    @(posedge clk);
    #1 cond(1'b1);
    frame(8'hA0, q, n[0]);
    frame(o, q, n[1]);
    cond(1'b1);
    frame(8'hA1, q, n[2]);
    frame(8'hFF, d, n[3]);  // trailing one is the closing nack
    cond(1'b0);
    ack = (n[2:0] === 3'h0);
  endtask
endmodule  // mms_host_model
`default_nettype wire

//--- dv/mms_mgmt_props.sv
// mms_mgmt_props: pin timing relations of mms_mgmt_top.
// assumes binding into mms_mgmt_top with a matching init count.
`default_nettype none
module mms_mgmt_props #(
  parameter int INIT_CYCLES = 200  // init time
) (
  input wire logic CLK,               // clock
  input wire logic RSTN,              // reset
  input wire logic SDA_OE,            // sda pull
  input wire logic MODULE_RESET_N,    // reset pin
  input wire logic MODULE_SELECT_N,   // select pin
  input wire logic LOW_POWER_SELECT,  // lp pin
  input wire logic INTERRUPT_OUT_N,   // interrupt
  input wire logic LOW_POWER_EN,      // lp enable
  input wire logic READY              // init done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  lo_q;   // run of low samples on the reset pin
  logic [31:0] age_q;  // cycles since the reset pin was last low, frozen while READY is high
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN) lo_q <= 8'h00;
    else if (MODULE_RESET_N) lo_q <= 8'h00;
    else if (lo_q != 8'hFF) lo_q <= lo_q + 8'h01;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN) age_q <= 32'h0;
    else if (!MODULE_RESET_N) age_q <= 32'h0;
    else if (!READY) age_q <= age_q + 32'h1;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_lp_on;
    LOW_POWER_SELECT [*4];
  endsequence
  sequence s_lp_off;
    !LOW_POWER_SELECT [*4];
  endsequence
  a_lp_enter: assert property (s_lp_on |=> LOW_POWER_EN)
    else $error("low power entry late");
  a_lp_leave: assert property (s_lp_off |=> !LOW_POWER_EN)
    else $error("low power exit late");
  a_select_quiet: assert property (MODULE_SELECT_N [*8] |-> !SDA_OE)
    else $error("bus driven while deselected");
  a_reset_min: assert property ($fell(READY) |-> lo_q >= 8'h32)
    else $error("short reset pulse accepted");
  a_reset_hold: assert property (lo_q == 8'h40 |-> !READY)
    else $error("long reset pulse ignored");
  a_init_time: assert property ($rose(READY) |->
    age_q >= INIT_CYCLES - 1 && age_q <= INIT_CYCLES + 5)
    else $error("init time off");
  a_init_bound: assert property (!READY |-> age_q <= INIT_CYCLES + 5)
    else $error("init overran");
  a_ready_int: assert property ($rose(READY) |-> ##[0:2] !INTERRUPT_OUT_N)
    else $error("no interrupt at ready");
endmodule  // mms_mgmt_props
`default_nettype wire

//--- dv/testbench.sv
// testbench: flags, interrupt, paging, select, power and reset pin.
// assumes mms_host_model as bus master and a shortened init count.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mms_pkg::*;
  localparam int INIT = 200;
  logic       clk, rstn, mrst_n, msel_n, lps, oe, sda_o, scl, sda;
  logic       intn, lpe, rdy, ak;
  logic [3:0] los, txf;
  logic [7:0] d, v, pa;
  int         errors, num_checks;
  mms_mgmt_top #(.INIT_CYCLES(INIT)) mms_mgmt_top_i (
    .CLK(clk), .RSTN(rstn), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(oe), .MODULE_RESET_N(mrst_n), .MODULE_SELECT_N(msel_n),
    .LOW_POWER_SELECT(lps), .RX_LOS(los), .TX_FAULT(txf),
    .INTERRUPT_OUT_N(intn), .LOW_POWER_EN(lpe), .READY(rdy));
  mms_host_model mms_host_model_i (
    .clk(clk), .sda_oe(oe), .scl(scl), .sda_w(sda));
  function automatic logic [7:0] flag_exp(input logic [7:0] x);
    return (8'(x[7:4]) << POS_FAULT) | (8'(x[3:0]) << POS_LOS);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_int(input logic e, input int n);
    for (int i = 0; i < n && intn !== e; i++) tick(1);
    chk("interrupt", 8'(intn), 8'(e));
    if (intn !== e) close_out();
  endtask
  task automatic rdc(input string nm, input logic [7:0] o, e);
    mms_host_model_i.rd(o, d, ak);
    chk(nm, d, e);
  endtask
  task automatic wr(input logic [7:0] o, x);
    mms_host_model_i.wr(o, x, ak);
    chk("write ack", 8'(ak), 8'h01);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rstn, lps, los, txf, msel_n} = '0;
    mrst_n = 1'b1;
    errors = 0;
    num_checks = 0;
    d = 8'($urandom(32'hFA2C6EF3));
    tick(10);
    rstn = 1'b1;
    tick(2);
    chk("ready early", 8'(rdy), 8'h00);
    wait_int(1'b0, INIT + 20);
    chk("ready", 8'(rdy), 8'h01);
    rdc("status", 8'(OFS_STATUS), 8'h00);
    rdc("id", 8'(OFS_ID), ID_VALUE);
    rdc("misc flags", 8'(OFS_FLAG_MISC), 8'h01);
    wait_int(1'b1, 20);
    rdc("misc clear", 8'(OFS_FLAG_MISC), 8'h00);
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'hFF : 8'($urandom) | 8'h01;
      {txf, los} = v;
      wait_int(1'b0, 10);
      rdc("lane flags", 8'(OFS_FLAG_LANE), flag_exp(v));
      wait_int(1'b1, 20);
      {txf, los} = 8'h00;
      tick(5);
    end
    wr(8'(OFS_MASK_LANE), 8'hFF);
    los = 4'h3;
    tick(20);
    chk("masked", 8'(intn), 8'h01);
    wr(8'(OFS_MASK_LANE), 8'h00);
    wait_int(1'b0, 10);
    rdc("misc idle", 8'(OFS_FLAG_MISC), 8'h00);
    chk("int held", 8'(intn), 8'h00);
    rdc("lane held", 8'(OFS_FLAG_LANE), 8'h03);
    wait_int(1'b1, 20);
    los = 4'h0;
    pa = 8'($urandom);
    wr(8'(OFS_PAGE_SEL), 8'h01);
    wr(8'h80, pa);
    wr(8'(OFS_PAGE_SEL), 8'h00);
    wr(8'h80, ~pa);
    rdc("page 0", 8'h80, ~pa);
    wr(8'(OFS_PAGE_SEL), 8'h01);
    rdc("page 1", 8'h80, pa);
    rdc("lower id", 8'(OFS_ID), ID_VALUE);
    lps = 1'b1;
    tick(5);
    chk("low power", 8'(lpe), 8'h01);
    lps = 1'b0;
    tick(5);
    chk("full power", 8'(lpe), 8'h00);
    msel_n = 1'b1;
    tick(10);
    mms_host_model_i.rd(8'(OFS_ID), d, ak);
    chk("deselected ack", 8'(ak), 8'h00);
    msel_n = 1'b0;
    tick(10);
    rdc("reselected", 8'(OFS_ID), ID_VALUE);
    mrst_n = 1'b0;
    tick(40);
    mrst_n = 1'b1;
    tick(10);
    chk("short reset", 8'(rdy), 8'h01);
    mrst_n = 1'b0;
    tick(60);
    chk("long reset", 8'(rdy), 8'h00);
    mrst_n = 1'b1;
    wait_int(1'b0, INIT + 20);
    chk("ready again", 8'(rdy), 8'h01);
    chk("sda drive", 8'(sda_o), 8'h00);
    wr(8'(OFS_MASK_MISC), 8'h01);
    wait_int(1'b1, 20);
    rdc("misc mask", 8'(OFS_MASK_MISC), 8'h01);
    rdc("misc masked", 8'(OFS_FLAG_MISC), 8'h01);
    close_out();
  end
endmodule  // testbench
bind mms_mgmt_top mms_mgmt_props #(.INIT_CYCLES(INIT_CYCLES)) mms_props_i (
  .CLK(CLK), .RSTN(RSTN), .SDA_OE(SDA_OE), .MODULE_RESET_N(MODULE_RESET_N),
  .MODULE_SELECT_N(MODULE_SELECT_N), .LOW_POWER_SELECT(LOW_POWER_SELECT),
  .INTERRUPT_OUT_N(INTERRUPT_OUT_N), .LOW_POWER_EN(LOW_POWER_EN),
  .READY(READY));
`default_nettype wire

//--- hdl/mms_mgmt_top.sv
// mms_mgmt_top: management memory, flags, interrupt, reset and low-power
// control of a four-lane module, reached over a two-wire serial slave.
// assumes all pin inputs are asynchronous to CLK; SDA is open drain.
`default_nettype none

// two flip-flop synchroniser for a vector of pin levels
module mms_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // core clock
  input  wire logic         rst_n,  // async reset
  input  wire logic [W-1:0] d,      // async level
  output logic      [W-1:0] q       // synchronised level
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // mms_sync

// Behaviour
// RULE_01 - lower page of 128 bytes always reachable; upper pages share top half
// RULE_02 - flags and monitors in lower page; id and thresholds in upper pages; the id here sits at lower page offset 00h
// RULE_03 - slave answers at device address A0h, interrupt data in one read
// RULE_04 - host reads the flag bytes after interrupt to find cause
// RULE_05 - fully functional within 2000 ms of power-on or reset release
// RULE_06 - only a reset pin low longer than 2 us counts as reset
// RULE_07 - bus answers within 2000 ms after power-on
// RULE_08 - data-not-ready bit clears and interrupt asserts within 2000 ms
// RULE_09 - low-power select high reduces power within 100 us
// RULE_10 - interrupt output goes low within 200 ms of any event
// RULE_11 - flags clear on read; interrupt releases within 500 us
// RULE_12 - loss-of-signal entry sets lane flag and interrupt within 100 ms
// RULE_13 - fully functional means interrupt raised by not-ready clearing
// RULE_14 - mask bit stops or resumes its flag's interrupt within 100 ms
// RULE_15 - bus answers only while module select is low, within 100 us
// RULE_16 - interrupt held while any unmasked flag stays set
// RULE_17 - upper half maps to page last written to page select; here only bit 0 of page select picks one of the 2 upper pages
module mms_mgmt_top
  import mms_pkg::*;
#(
  parameter int INIT_CYCLES = mms_pkg::INIT_CYC  // init time in cycles
) (
  input  wire logic       CLK,               // 25 MHz core clock
  input  wire logic       RSTN,              // async power-on reset
  input  wire logic       SCL,               // serial clock pin
  input  wire logic       SDA_I,             // serial data pin level
  output logic            SDA_O,             // serial data drive value
  output logic            SDA_OE,            // high while pulling SDA
  input  wire logic       MODULE_RESET_N,    // module reset pin
  input  wire logic       MODULE_SELECT_N,   // module select pin
  input  wire logic       LOW_POWER_SELECT,  // low-power mode pin
  input  wire logic [3:0] RX_LOS,            // per-lane loss of signal
  input  wire logic [3:0] TX_FAULT,          // per-lane transmit fault
  output logic            INTERRUPT_OUT_N,   // interrupt, active low
  output logic            LOW_POWER_EN,      // lower power level enable
  output logic            READY              // fully functional
);
  import mms_pkg::*;

  // synchronised pins
  logic [12:0] pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        mrst_n_s;
  logic        msel_n_s;
  logic        lp_s;
  logic [3:0]  los_s;
  logic [3:0]  fault_s;

  mms_sync #(.W(13)) u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .d     ({SCL, SDA_I, MODULE_RESET_N, MODULE_SELECT_N,
             LOW_POWER_SELECT, RX_LOS, TX_FAULT}),
    .q     (pins_s)
  );
  assign {scl_s, sda_s, mrst_n_s, msel_n_s, lp_s, los_s, fault_s} = pins_s;

  // state
  mms_bus_st_t        st_q;
  logic [3:0]         cnt_q;
  logic [7:0]         sh_q;
  logic [7:0]         tx_q;
  logic [7:0]         ptr_q;
  logic               first_q;
  logic               scl_p_q;
  logic               sda_p_q;
  logic [3:0]         los_p_q;
  logic [3:0]         fault_p_q;
  logic [7:0]         flag_lane_q;
  logic               flag_init_q;
  logic [7:0]         mask_lane_q;
  logic [7:0]         mask_misc_q;
  logic [7:0]         page_q;
  logic               not_ready_q;
  logic [INIT_W-1:0]  init_cnt_q;
  logic [RSTCNT_W-1:0] rst_cnt_q;
  logic [7:0]         upper_q [NUM_UPPER][PAGE_BYTES];

  // bus condition decode
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire selected  = ~msel_n_s;
  wire active    = (st_q == ST_ADDR) | (st_q == ST_WR) | (st_q == ST_RD);
  wire byte_end  = scl_fall & active & (cnt_q == 4'h8);
  wire rd_go     = (st_q == ST_ADDR) & sh_q[0];
  wire rd_load   = byte_end & ((st_q == ST_RD) | rd_go);
  wire wr_data   = byte_end & (st_q == ST_WR) & ~first_q;
  wire [6:0] ofs = ptr_q[6:0];
  wire upper     = ptr_q[7];
  wire pg        = page_q[0];

  // module reset pin qualification
  wire rst_hold  = (rst_cnt_q == RSTCNT_W'(RESET_MIN_CYC));
  wire init_end  = ~rst_hold & not_ready_q &
                   (init_cnt_q == INIT_W'(INIT_CYCLES - 1));

  // read data selection
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (upper) begin
      rd_byte = upper_q[pg][ofs];                              // RULE_17
    end else begin
      case (ofs)                                               // RULE_01
        OFS_ID:        rd_byte = ID_VALUE;
        OFS_STATUS:    rd_byte = 8'(not_ready_q) << BIT_NOT_READY;
        OFS_FLAG_LANE: rd_byte = flag_lane_q;                  // RULE_02
        OFS_FLAG_MISC: rd_byte = 8'(flag_init_q) << BIT_INIT_DONE;
        OFS_MASK_LANE: rd_byte = mask_lane_q;
        OFS_MASK_MISC: rd_byte = mask_misc_q;
        OFS_PAGE_SEL:  rd_byte = page_q;
        default:       rd_byte = 8'h00;
      endcase
    end
  end

  // clear-on-read strobes carry only the bits that were shown
  wire [7:0] clr_lane = (rd_load & ~upper & (ofs == OFS_FLAG_LANE)) ?
                        rd_byte : 8'h00;
  wire       clr_init = rd_load & ~upper & (ofs == OFS_FLAG_MISC) &
                        rd_byte[BIT_INIT_DONE];
  wire [7:0] ev_lane;
  assign ev_lane[POS_LOS +: 4]   = los_s & ~los_p_q;
  assign ev_lane[POS_FAULT +: 4] = fault_s & ~fault_p_q;

  wire irq = |(flag_lane_q & ~mask_lane_q) |
             (flag_init_q & ~mask_misc_q[BIT_INIT_DONE]);

  // edge history
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_p_q   <= 1'b0;
      sda_p_q   <= 1'b0;
      los_p_q   <= 4'h0;
      fault_p_q <= 4'h0;
    end else begin
      scl_p_q   <= scl_s;
      sda_p_q   <= sda_s;
      los_p_q   <= los_s;
      fault_p_q <= fault_s;
    end
  end

  // module reset pin: a low shorter than the minimum is ignored
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_cnt_q <= '0;
    end else if (mrst_n_s) begin
      rst_cnt_q <= '0;
    end else if (!rst_hold) begin
      rst_cnt_q <= rst_cnt_q + RSTCNT_W'(1);                   // RULE_06
    end
  end

  // initialisation timer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      init_cnt_q  <= '0;
      not_ready_q <= 1'b1;
    end else if (rst_hold) begin
      init_cnt_q  <= '0;
      not_ready_q <= 1'b1;
    end else if (init_end) begin
      not_ready_q <= 1'b0;                                     // RULE_08
    end else if (not_ready_q) begin
      init_cnt_q  <= init_cnt_q + INIT_W'(1);                  // RULE_05
    end
  end

  // flags: a new event wins over a clearing read in the same cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      flag_lane_q <= 8'h00;
      flag_init_q <= 1'b0;
    end else if (rst_hold) begin
      flag_lane_q <= 8'h00;
      flag_init_q <= 1'b0;
    end else begin
      flag_lane_q <= (flag_lane_q & ~clr_lane) | ev_lane;      // RULE_12
      flag_init_q <= (flag_init_q & ~clr_init) | init_end;     // RULE_13
    end
  end

  // host-written control bytes in the lower page
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_lane_q <= RST_MASK;
      mask_misc_q <= RST_MASK;
      page_q      <= RST_PAGE;
    end else if (wr_data & ~upper) begin
      if (ofs == OFS_MASK_LANE) mask_lane_q <= sh_q;           // RULE_14
      if (ofs == OFS_MASK_MISC) mask_misc_q <= sh_q;
      if (ofs == OFS_PAGE_SEL)  page_q      <= sh_q;           // RULE_17
    end
  end

  // upper page storage, no reset: contents are host data
  always_ff @(posedge CLK) begin
    if (wr_data & upper) begin
      upper_q[pg][ofs] <= sh_q;                                // RULE_02
    end
  end

  // two-wire slave; SDA changes only after SCL falls, or at once on deselect
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      first_q <= 1'b0;
      SDA_OE  <= 1'b0;
    end else if (!selected) begin
      st_q    <= ST_IDLE;                                      // RULE_15
      SDA_OE  <= 1'b0;
    end else if (bus_start) begin
      st_q    <= ST_ADDR;
      // the scl fall that follows start wraps this to zero before bit 7
      cnt_q   <= 4'hF;
      SDA_OE  <= 1'b0;
    end else if (bus_stop) begin
      st_q    <= ST_IDLE;
      SDA_OE  <= 1'b0;
    end else if (active & scl_rise) begin
      if (cnt_q != 4'h8) begin
        sh_q <= {sh_q[6:0], sda_s};
      end else if ((st_q == ST_RD) & sda_s) begin
        st_q <= ST_SKIP;
      end
    end else if (active & scl_fall) begin
      if (cnt_q == 4'h7) begin
        cnt_q <= 4'h8;
        case (st_q)
          ST_ADDR: begin
            if (sh_q[7:1] == DEV_ADDR) begin
              SDA_OE <= 1'b1;                                  // RULE_03
            end else begin
              st_q <= ST_SKIP;
            end
          end
          ST_WR:   SDA_OE <= 1'b1;
          default: SDA_OE <= 1'b0;
        endcase
      end else if (cnt_q == 4'h8) begin
        cnt_q <= 4'h0;
        if (rd_load) begin
          st_q   <= ST_RD;
          tx_q   <= rd_byte;
          SDA_OE <= ~rd_byte[7];
          ptr_q  <= ptr_q + 8'h01;
        end else if (st_q == ST_ADDR) begin
          st_q    <= ST_WR;
          first_q <= 1'b1;
          SDA_OE  <= 1'b0;
        end else begin
          SDA_OE  <= 1'b0;
          first_q <= 1'b0;
          ptr_q   <= first_q ? sh_q : ptr_q + 8'h01;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
        if (st_q == ST_RD) begin
          tx_q   <= {tx_q[6:0], 1'b0};
          SDA_OE <= ~tx_q[6];
        end
      end
    end
  end

  // pin-level outputs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SDA_O           <= 1'b0;
      INTERRUPT_OUT_N <= 1'b1;
      LOW_POWER_EN    <= 1'b0;
      READY           <= 1'b0;
    end else begin
      SDA_O           <= 1'b0;
      INTERRUPT_OUT_N <= ~irq;                 // RULE_10 RULE_11 RULE_16
      LOW_POWER_EN    <= lp_s;                                 // RULE_09
      READY           <= ~not_ready_q & ~rst_hold;             // RULE_07
    end
  end

endmodule // mms_mgmt_top
`default_nettype wire

//--- inc/mms_pkg.sv
// mms_pkg: constants for the module management and status block.
// assumes a 25 MHz core clock; all times are converted to cycles here.
`default_nettype none
package mms_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 40;
  // two-wire bus
  localparam logic [6:0] DEV_ADDR      = 7'h50;  // A0h as 8-bit write
  localparam logic [7:0] ID_VALUE      = 8'h5A;  // arbitrary identifier
  localparam int         NUM_UPPER     = 2;
  localparam int         PAGE_BYTES    = 128;
  // lower page offsets
  localparam logic [6:0] OFS_ID        = 7'h00;
  localparam logic [6:0] OFS_STATUS    = 7'h02;
  localparam logic [6:0] OFS_FLAG_LANE = 7'h03;
  localparam logic [6:0] OFS_FLAG_MISC = 7'h04;
  localparam logic [6:0] OFS_MASK_LANE = 7'h64;
  localparam logic [6:0] OFS_MASK_MISC = 7'h65;
  localparam logic [6:0] OFS_PAGE_SEL  = 7'h7F;
  // field positions
  localparam int BIT_NOT_READY  = 0;  // status byte
  localparam int BIT_INIT_DONE  = 0;  // misc flag byte
  localparam int POS_LOS        = 0;  // lane flags [3:0]
  localparam int POS_FAULT      = 4;  // lane flags [7:4]
  // reset values
  localparam logic [7:0] RST_MASK      = 8'h00;
  localparam logic [7:0] RST_PAGE      = 8'h00;
  // timing
  localparam int T_RESET_MIN_NS = 2000;
  localparam int RESET_MIN_CYC  =
    (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_INIT_MS      = 2000;
  localparam int INIT_CYC       = T_INIT_MS * (1000000 / CLK_PERIOD_NS);
  localparam int INIT_W         = 26;
  localparam int RSTCNT_W       = 6;
  // bus receiver states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WR, ST_RD, ST_SKIP
  } mms_bus_st_t;
endpackage
`default_nettype wire
